// ### pcimw_pkg.sv
// Purpose: Shared constants and types for the PCI master write path
// Assumes: 32-bit PCI bus, 32-bit local bus, one clock
// Notes: Burst length width is a plain default
package pcimw_pkg;
    localparam int AD_W = 32;
    localparam int BE_W = 4;
    localparam int LEN_W = 8;
    localparam int WORD_W = AD_W + BE_W;
    localparam int HOLD_DEPTH = 2;
    localparam int CNT_W = 2;
    localparam logic [LEN_W-1:0] LEN_ZERO = 8'h00;
    localparam logic [LEN_W-1:0] LEN_ONE = 8'h01;
    localparam logic [CNT_W-1:0] HOLD_ROOM = 2'h1;
    localparam logic [AD_W-1:0] AD_RESET = 32'h0000_0000;
    localparam logic [BE_W-1:0] BE_RESET = 4'hf;

    typedef enum logic [3:0]
    {
        PCIMW_IDLE = 4'h0,
        PCIMW_ADDR_LOAD = 4'h1,
        PCIMW_BUS_XFER = 4'h2,
        PCIMW_BUS_TERM = 4'h3
    } pcimw_state_t;

    typedef enum logic [1:0]
    {
        PCIMW_CAUSE_NONE = 2'h0,
        PCIMW_CAUSE_NORMAL = 2'h1
    } pcimw_cause_t;
endpackage : pcimw_pkg

// ### pcimw_word_hold.sv
// Purpose: Two-word hold for write data between local side and bus
// Assumes: Caller never pushes into a full hold
// Notes: Head and count are also given as next values
`timescale 1ns/1ns
`default_nettype none
module pcimw_word_hold (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic push,
    input wire logic pop,
    input wire logic [pcimw_pkg::WORD_W-1:0] din,
    output logic [pcimw_pkg::CNT_W-1:0] count,
    output logic [pcimw_pkg::CNT_W-1:0] next_count,
    output logic [pcimw_pkg::WORD_W-1:0] next_head
);
    logic [pcimw_pkg::WORD_W-1:0] entry [pcimw_pkg::HOLD_DEPTH];
    logic rd;
    logic wr;

    assign next_count = count + pcimw_pkg::CNT_W'(push) - pcimw_pkg::CNT_W'(pop);

    always_comb
    begin
        if (pop)
            next_head = (count > pcimw_pkg::HOLD_ROOM) ? entry[~rd] : din;
        else
            next_head = (count == '0) ? din : entry[rd];
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            count <= '0;
            rd <= 1'b0;
            wr <= 1'b0;
        end
        else
        begin
            count <= next_count;
            if (pop)
                rd <= ~rd;
            if (push)
                wr <= ~wr;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (push)
            entry[wr] <= din;
    end
endmodule : pcimw_word_hold
`default_nettype wire

// ### pcimw_parity.sv
// Purpose: Even parity over ad and cben, one clock behind them
// Assumes: Inputs are the registered bus drives
// Notes: Par drive follows ad drive by one clock
`timescale 1ns/1ns
`default_nettype none
module pcimw_parity (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [pcimw_pkg::AD_W-1:0] ad,
    input wire logic [pcimw_pkg::BE_W-1:0] cben,
    input wire logic ad_oe_n,
    output logic par_out,
    output logic par_oe_n
);
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            par_out <= 1'b0;
            par_oe_n <= 1'b1;
        end
        else
        begin
            par_out <= ^{ad, cben};
            par_oe_n <= ad_oe_n;
        end
    end
endmodule : pcimw_parity
`default_nettype wire

// ### pcimw_master_write.sv
// Purpose: PCI master write sequencing from a 32-bit local master
// Assumes: Single clock; pins are synchronous; no target abort
// Notes: Only normal termination is reported
`timescale 1ns/1ns
`default_nettype none
module pcimw_master_write (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic local_word_request_n,
    input wire logic [pcimw_pkg::AD_W-1:0] local_ad_in,
    input wire logic [pcimw_pkg::BE_W-1:0] local_cmd_byteen_in,
    input wire logic [pcimw_pkg::LEN_W-1:0] local_burst_len,
    input wire logic local_ready_n,
    output logic local_grant_n,
    output logic local_xfer_strobe_n,
    output logic [3:0] local_master_state,
    output logic [1:0] termination_cause,
    output logic [pcimw_pkg::LEN_W-1:0] burst_remaining_count,
    output logic reqn,
    input wire logic gntn,
    output logic [pcimw_pkg::AD_W-1:0] ad_out,
    output logic ad_oe_n,
    input wire logic [pcimw_pkg::AD_W-1:0] ad_in,
    output logic [pcimw_pkg::BE_W-1:0] cben_out,
    output logic cben_oe_n,
    output logic framen_out,
    output logic framen_oe_n,
    input wire logic framen_in,
    output logic irdyn_out,
    output logic irdyn_oe_n,
    input wire logic irdyn_in,
    input wire logic trdyn_in,
    input wire logic devseln_in,
    output logic par_out,
    output logic par_oe_n
);
    pcimw_pkg::pcimw_state_t state;
    pcimw_pkg::pcimw_state_t next_state;
    pcimw_pkg::pcimw_cause_t cause;
    logic [pcimw_pkg::AD_W-1:0] addr_q;
    logic [pcimw_pkg::BE_W-1:0] cmd_q;
    logic [pcimw_pkg::LEN_W-1:0] len_q;
    logic [pcimw_pkg::LEN_W-1:0] taken;
    logic [pcimw_pkg::LEN_W-1:0] next_taken;
    logic [pcimw_pkg::LEN_W-1:0] next_remaining;
    logic [pcimw_pkg::CNT_W-1:0] hold_count;
    logic [pcimw_pkg::CNT_W-1:0] next_hold_count;
    logic [pcimw_pkg::WORD_W-1:0] next_head;
    logic bus_idle;
    logic push;
    logic phase_done;
    logic start_ok;
    logic next_irdy_low;
    logic next_frame_low;
    logic next_strobe;

    assign local_master_state = state;
    assign termination_cause = cause;
    assign bus_idle = framen_in & irdyn_in;
    assign push = ~local_xfer_strobe_n;
    // Only our own asserted irdyn counts; the pin may still float high
    assign phase_done = (state == pcimw_pkg::PCIMW_BUS_XFER) & ~irdyn_out & ~trdyn_in;
    assign next_remaining = burst_remaining_count - pcimw_pkg::LEN_W'(phase_done);
    assign next_taken = taken + pcimw_pkg::LEN_W'(push);
    assign start_ok = ~local_word_request_n & ~gntn & ~local_grant_n & bus_idle;

    pcimw_word_hold u_hold (
        .sys_clk(sys_clk),
        .rst(rst),
        .push(push),
        .pop(phase_done),
        .din({local_cmd_byteen_in, local_ad_in}),
        .count(hold_count),
        .next_count(next_hold_count),
        .next_head(next_head)
    );

    pcimw_parity u_par (
        .sys_clk(sys_clk),
        .rst(rst),
        .ad(ad_out),
        .cben(cben_out),
        .ad_oe_n(ad_oe_n),
        .par_out(par_out),
        .par_oe_n(par_oe_n)
    );

    always_comb
    begin
        next_state = state;
        case (state)
            pcimw_pkg::PCIMW_IDLE:
                if (start_ok)
                    next_state = pcimw_pkg::PCIMW_ADDR_LOAD;
            pcimw_pkg::PCIMW_ADDR_LOAD:
                // Lost grant or empty burst: give up quietly
                if (~gntn & (len_q != pcimw_pkg::LEN_ZERO))
                    next_state = pcimw_pkg::PCIMW_BUS_XFER;
                else
                    next_state = pcimw_pkg::PCIMW_IDLE;
            pcimw_pkg::PCIMW_BUS_XFER:
                if (next_remaining == pcimw_pkg::LEN_ZERO)
                    next_state = pcimw_pkg::PCIMW_BUS_TERM;
            pcimw_pkg::PCIMW_BUS_TERM:
                next_state = pcimw_pkg::PCIMW_IDLE;
            default:
                next_state = pcimw_pkg::PCIMW_IDLE;
        endcase
    end

    always_comb
    begin
        // Wait state when no word will be held for the bus
        next_irdy_low = (state == pcimw_pkg::PCIMW_BUS_XFER) &
                        (next_state == pcimw_pkg::PCIMW_BUS_XFER) &
                        (next_hold_count != '0);
        next_frame_low = 1'b0;
        if (state == pcimw_pkg::PCIMW_ADDR_LOAD)
            next_frame_low = (next_state == pcimw_pkg::PCIMW_BUS_XFER);
        else if ((next_state == pcimw_pkg::PCIMW_BUS_XFER) & ~framen_out)
            next_frame_low = ~(next_irdy_low & (next_remaining == pcimw_pkg::LEN_ONE));
        // Room check keeps a push from overrunning the two-word hold
        next_strobe = (next_state == pcimw_pkg::PCIMW_BUS_XFER) & ~local_ready_n &
                      (next_hold_count <= pcimw_pkg::HOLD_ROOM) &
                      (next_taken < len_q);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            state <= pcimw_pkg::PCIMW_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            addr_q <= pcimw_pkg::AD_RESET;
            cmd_q <= pcimw_pkg::BE_RESET;
            len_q <= pcimw_pkg::LEN_ZERO;
        end
        else if ((state == pcimw_pkg::PCIMW_IDLE) & start_ok)
        begin
            addr_q <= local_ad_in;
            cmd_q <= local_cmd_byteen_in;
            len_q <= local_burst_len;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            reqn <= 1'b1;
        else if (state == pcimw_pkg::PCIMW_IDLE)
            reqn <= local_word_request_n;
        else if (~framen_out & ~framen_oe_n & local_word_request_n)
            reqn <= 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            local_grant_n <= 1'b1;
        else if (gntn)
            local_grant_n <= 1'b1;
        else if ((state == pcimw_pkg::PCIMW_IDLE) & bus_idle & ~reqn)
            local_grant_n <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            local_xfer_strobe_n <= 1'b1;
        else
            local_xfer_strobe_n <= ~next_strobe;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            taken <= pcimw_pkg::LEN_ZERO;
        // Cleared outside bursts; a stale count would starve the next first strobe
        else if (state != pcimw_pkg::PCIMW_BUS_XFER)
            taken <= pcimw_pkg::LEN_ZERO;
        else
            taken <= next_taken;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            burst_remaining_count <= pcimw_pkg::LEN_ZERO;
        else if (state == pcimw_pkg::PCIMW_ADDR_LOAD)
            burst_remaining_count <= len_q;
        else
            burst_remaining_count <= next_remaining;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            framen_out <= 1'b1;
            framen_oe_n <= 1'b1;
        end
        else
        begin
            framen_out <= ~next_frame_low;
            framen_oe_n <= (next_state != pcimw_pkg::PCIMW_BUS_XFER);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ad_out <= pcimw_pkg::AD_RESET;
            cben_out <= pcimw_pkg::BE_RESET;
            ad_oe_n <= 1'b1;
            cben_oe_n <= 1'b1;
        end
        else
        begin
            ad_oe_n <= (next_state != pcimw_pkg::PCIMW_BUS_XFER);
            cben_oe_n <= (next_state != pcimw_pkg::PCIMW_BUS_XFER);
            if (state == pcimw_pkg::PCIMW_ADDR_LOAD)
            begin
                ad_out <= addr_q;
                cben_out <= cmd_q;
            end
            else if (next_hold_count != '0)
            begin
                // Held word reaches the bus once the pending phase is done
                ad_out <= next_head[pcimw_pkg::AD_W-1:0];
                cben_out <= next_head[pcimw_pkg::WORD_W-1:pcimw_pkg::AD_W];
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            irdyn_out <= 1'b1;
            irdyn_oe_n <= 1'b1;
        end
        else
        begin
            irdyn_out <= ~next_irdy_low;
            irdyn_oe_n <= (next_state == pcimw_pkg::PCIMW_IDLE) |
                          (next_state == pcimw_pkg::PCIMW_ADDR_LOAD);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            cause <= pcimw_pkg::PCIMW_CAUSE_NONE;
        else if (state == pcimw_pkg::PCIMW_ADDR_LOAD)
            cause <= pcimw_pkg::PCIMW_CAUSE_NONE;
        else if (phase_done & (next_state == pcimw_pkg::PCIMW_BUS_TERM))
            cause <= pcimw_pkg::PCIMW_CAUSE_NORMAL;
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    property p_req_up;
        (state == pcimw_pkg::PCIMW_IDLE) && !local_word_request_n |=> !reqn;
    endproperty
    a_req_up: assert property (p_req_up) else $error("reqn not asserted after request");

    property p_grant_on;
        (state == pcimw_pkg::PCIMW_IDLE) && !gntn && bus_idle && !reqn |=> !local_grant_n;
    endproperty
    a_grant_on: assert property (p_grant_on) else $error("local grant missing");

    property p_addr_load;
        (state == pcimw_pkg::PCIMW_IDLE) && start_ok
        |=> (local_master_state == 4'h1) && (addr_q == $past(local_ad_in));
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("address loading not entered");

    property p_addr_phase;
        (state == pcimw_pkg::PCIMW_ADDR_LOAD) && !gntn && (len_q != pcimw_pkg::LEN_ZERO)
        |=> !framen_out && !framen_oe_n && !ad_oe_n && (ad_out == addr_q) && (cben_out == cmd_q)
            && (local_master_state == 4'h2) && (burst_remaining_count == len_q);
    endproperty
    a_addr_phase: assert property (p_addr_phase) else $error("address phase wrong");

    property p_strobe;
        !local_xfer_strobe_n |-> $past(!local_ready_n);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe without prior ready");

    property p_reqn_off;
        (state != pcimw_pkg::PCIMW_IDLE) && !framen_out && !framen_oe_n && local_word_request_n |=> reqn;
    endproperty
    a_reqn_off: assert property (p_reqn_off) else $error("reqn held after framen");

    property p_grant_off;
        gntn |=> local_grant_n;
    endproperty
    a_grant_off: assert property (p_grant_off) else $error("local grant ignores gntn");

    property p_count_step;
        (state == pcimw_pkg::PCIMW_BUS_XFER) && !irdyn_out && !trdyn_in
        |=> burst_remaining_count == $past(burst_remaining_count) - 8'h01;
    endproperty
    a_count_step: assert property (p_count_step) else $error("burst count not decremented");

    property p_count_hold;
        (state == pcimw_pkg::PCIMW_BUS_XFER) && (irdyn_out || trdyn_in) |=> $stable(burst_remaining_count);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("count moved without phase");

    property p_wait;
        (state == pcimw_pkg::PCIMW_BUS_XFER) && (hold_count == '0) |-> irdyn_out;
    endproperty
    a_wait: assert property (p_wait) else $error("irdyn asserted without data");

    property p_last;
        (state == pcimw_pkg::PCIMW_BUS_XFER) && !irdyn_out && framen_out |-> burst_remaining_count == 8'h01;
    endproperty
    a_last: assert property (p_last) else $error("framen released early");

    property p_turn;
        phase_done && (burst_remaining_count == 8'h01)
        |=> (local_master_state == 4'h3) && framen_oe_n && ad_oe_n && cben_oe_n
            && !irdyn_oe_n && irdyn_out && (termination_cause == 2'h1)
        ##1 irdyn_oe_n && par_oe_n && (local_master_state == 4'h0);
    endproperty
    a_turn: assert property (p_turn) else $error("turnaround or idle wrong");

    property p_cause_hold;
        (state == pcimw_pkg::PCIMW_IDLE) |=> $stable(termination_cause);
    endproperty
    a_cause_hold: assert property (p_cause_hold) else $error("cause changed while idle");

    c_full_burst: cover property ((state == pcimw_pkg::PCIMW_BUS_TERM) && (termination_cause == 2'h1));
    c_wait_state: cover property ((state == pcimw_pkg::PCIMW_BUS_XFER) && irdyn_out && !framen_out);
    c_hold_full: cover property (hold_count == 2'h2);
    c_fast_target: cover property (!framen_out && !devseln_in && !trdyn_in && (ad_in == ad_out));
endmodule : pcimw_master_write
`default_nettype wire

// ### pcimw_target_model.sv
// Purpose: PCI target partner for the master write bench
// Assumes: Fast decode only; devseln and trdyn have pull-ups when released
// Notes: Trdyn can be held off some cycles to stall the first data phase
`timescale 1ns/1ns
`default_nettype none
module pcimw_target_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic framen,
    input wire logic irdyn,
    input wire logic [3:0] delay,
    output logic trdyn_n,
    output logic devseln_n
);
    logic framen_q;
    logic active;
    logic [3:0] wcnt;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            framen_q <= 1'b1;
            active <= 1'b0;
            wcnt <= 4'h0;
            trdyn_n <= 1'b1;
            devseln_n <= 1'b1;
        end
        else
        begin
            framen_q <= framen;
            if (!active && framen_q && !framen)
            begin
                // Claim in the cycle after the address phase
                active <= 1'b1;
                devseln_n <= 1'b0;
                wcnt <= delay;
                trdyn_n <= (delay != 4'h0);
            end
            else if (active && !trdyn_n && !irdyn && framen)
            begin
                // Last phase done; release, pull-ups take the lines high
                active <= 1'b0;
                trdyn_n <= 1'b1;
                devseln_n <= 1'b1;
            end
            else if (active && wcnt != 4'h0)
            begin
                wcnt <= wcnt - 4'h1;
                trdyn_n <= (wcnt != 4'h1);
            end
        end
    end
endmodule : pcimw_target_model
`default_nettype wire

// ### pcimw_master_write_tb.sv
// Purpose: Self-checking bench for the PCI master write sequencer
// Assumes: Bench acts as local master and arbiter; target is a model
// Notes: A monitor judges every data phase while the tasks run
`timescale 1ns/1ns
`default_nettype none
module pcimw_master_write_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic local_word_request_n = 1'b1;
    logic local_ready_n = 1'b1;
    logic gntn = 1'b1;
    logic in_req = 1'b1;
    logic act = 1'b0;
    logic [31:0] req_addr = 32'h0;
    logic [3:0] req_cmd = 4'h0;
    logic [7:0] req_len = 8'h0;
    logic [3:0] tdelay = 4'h0;
    logic [31:0] wd [8];
    logic [3:0] wbe [8];
    int widx = 0;
    int rel = 0;
    int gap = 99;
    int ph = 0;
    int exp_len = 0;
    int nstrobe = 0;
    int nwait = 0;
    int cyc = 0;
    int failures = 0;
    int n_compared = 0;
    logic rdy_q = 1'b1;
    logic s_strobe;
    logic [35:0] prev_adcb = 36'h0;
    logic [31:0] local_ad_in, ad_out, ad_pin;
    logic [3:0] local_cmd_byteen_in, cben_out, local_master_state;
    logic [7:0] local_burst_len, burst_remaining_count;
    logic [1:0] termination_cause;
    logic local_grant_n, local_xfer_strobe_n, reqn, ad_oe_n, cben_oe_n;
    logic framen_out, framen_oe_n, framen_pin, irdyn_out, irdyn_oe_n, irdyn_pin;
    logic trdyn_in, devseln_in, par_out, par_oe_n;

    // Request group while asking, data words afterwards
    assign local_ad_in = in_req ? req_addr : wd[widx[2:0]];
    assign local_cmd_byteen_in = in_req ? req_cmd : wbe[widx[2:0]];
    assign local_burst_len = req_len;
    // Pull-ups on control; ad shows the inverse when released, so no stale match
    assign framen_pin = framen_oe_n ? 1'b1 : framen_out;
    assign irdyn_pin = irdyn_oe_n ? 1'b1 : irdyn_out;
    assign ad_pin = ad_oe_n ? ~ad_out : ad_out;

    pcimw_master_write i_pcimw_master_write (.sys_clk(sys_clk), .rst(rst),
        .local_word_request_n(local_word_request_n), .local_ad_in(local_ad_in),
        .local_cmd_byteen_in(local_cmd_byteen_in), .local_burst_len(local_burst_len),
        .local_ready_n(local_ready_n), .local_grant_n(local_grant_n), .local_xfer_strobe_n(local_xfer_strobe_n),
        .local_master_state(local_master_state), .termination_cause(termination_cause),
        .burst_remaining_count(burst_remaining_count), .reqn(reqn), .gntn(gntn), .ad_out(ad_out),
        .ad_oe_n(ad_oe_n), .ad_in(ad_pin), .cben_out(cben_out), .cben_oe_n(cben_oe_n),
        .framen_out(framen_out), .framen_oe_n(framen_oe_n), .framen_in(framen_pin),
        .irdyn_out(irdyn_out), .irdyn_oe_n(irdyn_oe_n), .irdyn_in(irdyn_pin), .trdyn_in(trdyn_in),
        .devseln_in(devseln_in), .par_out(par_out), .par_oe_n(par_oe_n));

    pcimw_target_model i_pcimw_target_model (.sys_clk(sys_clk), .rst(rst), .framen(framen_pin),
        .irdyn(irdyn_pin), .delay(tdelay), .trdyn_n(trdyn_in), .devseln_n(devseln_in));

    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask : tick

    // Run is some 60 cycles; the ceiling only catches a hang
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    // Local master: advance after each strobe, ready while active and out of idle except in the gap cycle
    always @(posedge sys_clk)
    begin
        s_strobe = local_xfer_strobe_n;
        #1;
        if (s_strobe === 1'b0)
            widx++;
        if (local_master_state === 4'h1)
            rel = 0;
        else
            rel++;
        local_ready_n = !(act && rel != gap && local_master_state !== 4'h0);
    end

    // Monitor of strobes, data phases, waits and parity
    always @(posedge sys_clk)
    begin
        if (!rst)
        begin
            if (rdy_q === 1'b1)
                check(36'(local_xfer_strobe_n), 36'h1);
            if (local_xfer_strobe_n === 1'b0)
                nstrobe++;
            if (local_master_state === 4'h2 && irdyn_oe_n === 1'b0 && irdyn_out === 1'b0 && trdyn_in === 1'b0)
            begin
                check({cben_out, ad_out}, {wbe[ph[2:0]], wd[ph[2:0]]});
                check(36'(framen_out), 36'(ph == exp_len - 1));
                check(36'(burst_remaining_count), 36'(exp_len - ph));
                ph++;
            end
            else if (local_master_state === 4'h2 && ph > 0 && irdyn_out === 1'b1)
                nwait++;
            if (par_oe_n === 1'b0)
                check(36'(par_out), 36'(^prev_adcb));
        end
        prev_adcb = {ad_out, cben_out};
        rdy_q = local_ready_n;
    end

    task automatic start_req(input logic [31:0] addr, input logic [3:0] cmd, input logic [7:0] len);
        req_addr = addr;
        req_cmd = cmd;
        req_len = len;
        in_req = 1'b1;
        local_word_request_n = 1'b0;
        tick();
        check(36'(reqn), 36'h0);
        gntn = 1'b0;
        tick();
        check(36'(local_grant_n), 36'h0);
        tick();
        check(36'(local_master_state), 36'h1);
    endtask : start_req

    task automatic run_write(input logic [31:0] addr, input logic [3:0] cmd, input logic [7:0] len,
        input int gap_v, input logic [3:0] tdel);
        int n;
        for (n = 0; n < 8; n++)
        begin
            wd[n] = ~addr + 32'(n);
            wbe[n] = 4'(n) ^ cmd;
        end
        gap = gap_v;
        tdelay = tdel;
        ph = 0;
        nwait = 0;
        exp_len = int'(len);
        widx = 0;
        act = 1'b1;
        nstrobe = 0;
        start_req(addr, cmd, len);
        local_word_request_n = 1'b1;
        in_req = 1'b0;
        tick();
        check(36'(local_master_state), 36'h2);
        check(36'({framen_oe_n, framen_out, ad_oe_n, cben_oe_n}), 36'h0);
        check({cben_out, ad_out}, {cmd, addr});
        check(36'(burst_remaining_count), 36'(len));
        check(36'(local_xfer_strobe_n), 36'h0);
        gntn = 1'b1;
        tick();
        check(36'(reqn), 36'h1);
        check(36'(local_grant_n), 36'h1);
        n = 0;
        while (local_master_state !== 4'h3 && n < 60)
        begin
            tick();
            n++;
        end
        check(36'(termination_cause), 36'h1);
        check(36'({framen_oe_n, ad_oe_n, cben_oe_n, irdyn_oe_n, irdyn_out}), 36'h1d);
        check(36'(burst_remaining_count), 36'h0);
        check(36'(ph), 36'(len));
        check(36'(nstrobe), 36'(len));
        tick();
        check(36'({local_master_state, irdyn_oe_n, par_oe_n}), 36'h3);
        check(36'(termination_cause), 36'h1);
        if (gap_v < 99)
            check(36'(nwait > 0), 36'h1);
        act = 1'b0;
        tick();
    endtask : run_write

    // Grant taken away during address loading: quiet return to idle
    task automatic grant_loss;
        start_req(32'h0000_0c00, 4'h7, 8'h02);
        gntn = 1'b1;
        local_word_request_n = 1'b1;
        in_req = 1'b0;
        tick();
        check(36'(local_master_state), 36'h0);
        check(36'(framen_oe_n), 36'h1);
        check(36'(termination_cause), 36'h0);
        repeat (3) tick();
    endtask : grant_loss

    // Zero burst length: abandoned in address loading, bus never driven
    task automatic zero_len;
        start_req(32'h0000_0d00, 4'h7, 8'h00);
        local_word_request_n = 1'b1;
        in_req = 1'b0;
        tick();
        check(36'(local_master_state), 36'h0);
        check(36'(framen_oe_n), 36'h1);
        check(36'(termination_cause), 36'h0);
        gntn = 1'b1;
        repeat (3) tick();
    endtask : zero_len

    initial
    begin
        repeat (12) @(posedge sys_clk);
        #1;
        check(36'({reqn, local_grant_n, local_xfer_strobe_n}), 36'h7);
        check(36'({local_master_state, termination_cause}), 36'h0);
        check(36'({ad_oe_n, cben_oe_n, framen_oe_n, irdyn_oe_n, par_oe_n, burst_remaining_count}), 36'h1f00);
        rst = 1'b0;
        tick();
        run_write(32'h0000_4000, 4'h7, 8'h03, 2, 4'h0);
        run_write(32'h0000_8010, 4'hf, 8'h04, 99, 4'h3);
        // Short burst right after a longer one: no count may carry over
        run_write(32'h0001_0020, 4'h7, 8'h01, 99, 4'h0);
        grant_loss();
        zero_len();
        tally_and_finish();
    end
endmodule : pcimw_master_write_tb
`default_nettype wire
